// ==== pkg/cos_pkg.sv ====
// constants, register map and field layout of the output steering block
//
// Summary of operation
// - source 3 on: logic cell two low forces shutdown
// - source 2 on: comparator 2 low forces shutdown
// - source 1 on: comparator 1 low forces shutdown
// - source 0 on: mapped shutdown pin low forces shutdown
// - unused upper register bits read zero
// - steering set: waveform after polarity drives the output
// - steering clear: output driven from its static level bit
// - static levels D,C,B,A at bits 7..4; one high
// - rise timebase 0: primary delayed rise count clocks
// - rise timebase 1: primary delayed rise count chain steps
// - fall timebase 0: complementary delayed fall count clocks
// - fall timebase 1: complementary delayed fall count steps
// - rising event blanks falling events for rise blank count
// - shutdown: each pair takes 11 hi, 10 lo, 01 z, 00 idle
// - status reads one in shutdown; auto restart on rising event
// - falling event blanks rising events for fall blank count
package cos_pkg;
    // byte addresses of the registers on the bus
    localparam logic [7:0] ADDR_SRC_EN = 8'h00;
    localparam logic [7:0] ADDR_STEER = 8'h04;
    localparam logic [7:0] ADDR_RISE_DB = 8'h08;
    localparam logic [7:0] ADDR_FALL_DB = 8'h0C;
    localparam logic [7:0] ADDR_RISE_BLK = 8'h10;
    localparam logic [7:0] ADDR_FALL_BLK = 8'h14;
    localparam logic [7:0] ADDR_CTRL = 8'h18;
    localparam logic [7:0] ADDR_INT_STAT = 8'h1C;
    localparam logic [7:0] ADDR_INT_MASK = 8'h20;
    // control and steering register field positions
    localparam int CTRL_OVR_AC_LO = 0;
    localparam int CTRL_OVR_BD_LO = 2;
    localparam int CTRL_POL_LO = 4;
    localparam int CTRL_RESTART = 8;
    localparam int CTRL_RISE_TB = 9;
    localparam int CTRL_FALL_TB = 10;
    localparam int CTRL_SHUT_FLAG = 11;
    localparam int STEER_STATIC_LO = 4;
    // interrupt status bits
    localparam int IRQ_SHUT = 0;
    localparam int IRQ_RISE = 1;
    localparam int IRQ_FALL = 2;
    // reset values
    localparam logic [3:0] SRC_EN_RST = 4'h0;
    localparam logic [7:0] STEER_RST = 8'h00;
    localparam logic [5:0] COUNT_RST = 6'h00;
    localparam logic [10:0] CTRL_RST = 11'h000;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // override level codes
    localparam logic [1:0] OVR_HIGH = 2'h3;
    localparam logic [1:0] OVR_LOW = 2'h2;
    localparam logic [1:0] OVR_TRI = 2'h1;
    localparam logic [1:0] OVR_IDLE = 2'h0;
    // delay chain element period in generator clocks
    localparam int CHAIN_STEP_NS = 8;
    localparam int CLK_PERIOD_NS = 8;
    localparam logic [3:0] CHAIN_STEP_CYC =
        4'((CHAIN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    typedef enum logic [1:0] {
        DLY_IDLE = 2'b01,
        DLY_RUN = 2'b10
    } cos_dly_state_type;
endpackage

// ==== verilog/cos_edge_delay.sv ====
// one edge delay timer counting clocks or delay chain steps
`timescale 1ns/100ps
module cos_edge_delay
    import cos_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // control
    input wire logic start,
    input wire logic [5:0] count,
    input wire logic chainBase,
    // result
    output logic done
);
    cos_dly_state_type state_r, state_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [3:0] step_r, step_nxt;
    logic done_r, done_nxt;

    // step prescaler makes chain periods out of clocks
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        step_nxt = step_r;
        done_nxt = 1'b0;
        unique case (state_r)
            DLY_IDLE: begin
                if (start) begin
                    if (count == COUNT_RST) begin
                        done_nxt = 1'b1;
                    end else begin
                        state_nxt = DLY_RUN;
                        cnt_nxt = count;
                        step_nxt = 4'h1;
                    end
                end
            end
            DLY_RUN: begin
                // a chain step ends after CHAIN_STEP_CYC clocks
                if (!chainBase || step_r >= CHAIN_STEP_CYC) begin
                    step_nxt = 4'h1;
                    cnt_nxt = cnt_r - 6'h01;
                    if (cnt_r == 6'h01) begin
                        state_nxt = DLY_IDLE;
                        done_nxt = 1'b1;
                    end
                end else begin
                    step_nxt = step_r + 4'h1;
                end
                // a fresh start restarts the count
                if (start) begin
                    cnt_nxt = count;
                    step_nxt = 4'h1;
                    done_nxt = (count == COUNT_RST);
                    state_nxt = (count == COUNT_RST) ? DLY_IDLE : DLY_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_r <= DLY_IDLE;
            cnt_r <= COUNT_RST;
            step_r <= 4'h1;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            step_r <= step_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule

// ==== verilog/cos_top.sv ====
// output steering, shutdown, dead band and blanking of the output generator
`timescale 1ns/100ps
module cos_top
    import cos_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // event inputs from the generator
    input wire logic riseEvent,
    input wire logic fallEvent,
    // shutdown sources, all active low
    input wire logic shutdownPinMapping,
    input wire logic comparator1Out,
    input wire logic comparator2Out,
    input wire logic logicCellTwoOutput,
    // driver outputs a..d with enables
    output logic [3:0] outputLevel,
    output logic [3:0] outputEnable,
    // interrupt
    output logic irq
);
    // software state
    logic [3:0] srcEn_r, srcEn_nxt;
    logic [7:0] steer_r, steer_nxt;
    logic [5:0] riseDb_r, riseDb_nxt, fallDb_r, fallDb_nxt;
    logic [5:0] riseBlk_r, riseBlk_nxt, fallBlk_r, fallBlk_nxt;
    logic [10:0] ctrl_r, ctrl_nxt;
    logic [2:0] irqStat_r, irqStat_nxt, irqMask_r, irqMask_nxt;
    // bus data phase state
    logic wrPend_r, wrPend_nxt;
    logic [7:0] wrAddr_r, wrAddr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // waveform state
    logic shut_r, shut_nxt;
    logic wave_r, wave_nxt;
    logic primary_r, primary_nxt, compl_r, compl_nxt;
    logic [5:0] blkCnt_r, blkCnt_nxt;
    logic blkFall_r, blkFall_nxt;
    logic [3:0] outLvl_r, outLvl_nxt, outEn_r, outEn_nxt;
    logic irq_r, irq_nxt;
    // combinational helpers
    logic addrOk, srcLow, riseOk, fallOk, riseDone, fallDone;
    logic [3:0] wave4, polar;
    logic [7:0] selAddr;

    // read mux over the register file
    function automatic logic [31:0] readReg(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            ADDR_SRC_EN: v = {28'h0, srcEn_r};
            ADDR_STEER: v = {24'h0, steer_r};
            ADDR_RISE_DB: v = {26'h0, riseDb_r};
            ADDR_FALL_DB: v = {26'h0, fallDb_r};
            ADDR_RISE_BLK: v = {26'h0, riseBlk_r};
            ADDR_FALL_BLK: v = {26'h0, fallBlk_r};
            ADDR_CTRL: v = {20'h0, shut_r, ctrl_r};
            ADDR_INT_STAT: v = {29'h0, irqStat_r};
            ADDR_INT_MASK: v = {29'h0, irqMask_r};
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    assign selAddr = haddr[7:0];
    assign addrOk = hsel && hready && htrans == HTRANS_NONSEQ;

    // bus slave: zero wait states, writes land in the data phase
    always_comb begin
        wrPend_nxt = 1'b0;
        wrAddr_nxt = wrAddr_r;
        rdata_nxt = rdata_r;
        if (addrOk) begin
            wrPend_nxt = hwrite;
            wrAddr_nxt = selAddr;
            if (!hwrite) begin
                rdata_nxt = readReg(selAddr);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
        end else begin
            wrPend_r <= wrPend_nxt;
            wrAddr_r <= wrAddr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // register writes; interrupt flags set wins over write-one clear
    always_comb begin
        srcEn_nxt = srcEn_r;
        steer_nxt = steer_r;
        riseDb_nxt = riseDb_r;
        fallDb_nxt = fallDb_r;
        riseBlk_nxt = riseBlk_r;
        fallBlk_nxt = fallBlk_r;
        ctrl_nxt = ctrl_r;
        irqMask_nxt = irqMask_r;
        irqStat_nxt = irqStat_r;
        if (wrPend_r) begin
            unique case (wrAddr_r)
                ADDR_SRC_EN: srcEn_nxt = hwdata[3:0];
                ADDR_STEER: steer_nxt = hwdata[7:0];
                ADDR_RISE_DB: riseDb_nxt = hwdata[5:0];
                ADDR_FALL_DB: fallDb_nxt = hwdata[5:0];
                ADDR_RISE_BLK: riseBlk_nxt = hwdata[5:0];
                ADDR_FALL_BLK: fallBlk_nxt = hwdata[5:0];
                ADDR_CTRL: ctrl_nxt = hwdata[10:0];
                ADDR_INT_MASK: irqMask_nxt = hwdata[2:0];
                ADDR_INT_STAT: irqStat_nxt = irqStat_r & ~hwdata[2:0];
                default: ;
            endcase
        end
        irqStat_nxt[IRQ_SHUT] = irqStat_nxt[IRQ_SHUT] | (shut_nxt & ~shut_r);
        irqStat_nxt[IRQ_RISE] = irqStat_nxt[IRQ_RISE] | riseOk;
        irqStat_nxt[IRQ_FALL] = irqStat_nxt[IRQ_FALL] | fallOk;
        irq_nxt = |(irqStat_nxt & irqMask_nxt);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            srcEn_r <= SRC_EN_RST;
            steer_r <= STEER_RST;
            riseDb_r <= COUNT_RST;
            fallDb_r <= COUNT_RST;
            riseBlk_r <= COUNT_RST;
            fallBlk_r <= COUNT_RST;
            ctrl_r <= CTRL_RST;
            irqMask_r <= IRQ_RST;
            irqStat_r <= IRQ_RST;
            irq_r <= 1'b0;
        end else begin
            srcEn_r <= srcEn_nxt;
            steer_r <= steer_nxt;
            riseDb_r <= riseDb_nxt;
            fallDb_r <= fallDb_nxt;
            riseBlk_r <= riseBlk_nxt;
            fallBlk_r <= fallBlk_nxt;
            ctrl_r <= ctrl_nxt;
            irqMask_r <= irqMask_nxt;
            irqStat_r <= irqStat_nxt;
            irq_r <= irq_nxt;
        end
    end

    // any enabled source held low forces shutdown
    assign srcLow = (srcEn_r[3] & ~logicCellTwoOutput)
        | (srcEn_r[2] & ~comparator2Out)
        | (srcEn_r[1] & ~comparator1Out)
        | (srcEn_r[0] & ~shutdownPinMapping);

    // blanking gates the opposite event while the counter runs
    assign riseOk = riseEvent && !(blkFall_r == 1'b1 && blkCnt_r != 6'h00);
    assign fallOk = fallEvent && !(blkFall_r == 1'b0 && blkCnt_r != 6'h00)
        && !riseOk;

    // event handling, blanking and shutdown state
    always_comb begin
        shut_nxt = shut_r;
        wave_nxt = wave_r;
        blkCnt_nxt = (blkCnt_r != 6'h00) ? blkCnt_r - 6'h01 : blkCnt_r;
        blkFall_nxt = blkFall_r;
        primary_nxt = primary_r;
        compl_nxt = compl_r;
        if (riseOk) begin
            wave_nxt = 1'b1;
            compl_nxt = 1'b0;
            blkCnt_nxt = riseBlk_r;
            blkFall_nxt = 1'b0;
        end
        if (fallOk) begin
            wave_nxt = 1'b0;
            primary_nxt = 1'b0;
            blkCnt_nxt = fallBlk_r;
            blkFall_nxt = 1'b1;
        end
        // primary rises only after the rise dead band ran out
        if (riseDone && wave_r) begin
            primary_nxt = 1'b1;
        end
        if (fallDone && !wave_r) begin
            compl_nxt = 1'b1;
        end
        // auto restart only on a rising event once sources have cleared
        if (srcLow) begin
            shut_nxt = 1'b1;
        end else if (shut_r && ctrl_r[CTRL_RESTART] && riseOk) begin
            shut_nxt = 1'b0;
        end
        if (wrPend_r && wrAddr_r == ADDR_CTRL && !hwdata[CTRL_SHUT_FLAG]
                && !srcLow) begin
            shut_nxt = 1'b0; // software clears shutdown by writing zero
        end
    end

    // dead band timers: rise feeds primary, fall feeds complementary
    cos_edge_delay u_rise_dly (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .start(riseOk),
        .count(riseDb_r),
        .chainBase(ctrl_r[CTRL_RISE_TB]),
        .done(riseDone)
    );
    cos_edge_delay u_fall_dly (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .start(fallOk),
        .count(fallDb_r),
        .chainBase(ctrl_r[CTRL_FALL_TB]),
        .done(fallDone)
    );

    // outputs a,b follow primary; c,d the complementary waveform
    assign wave4 = {compl_r, compl_r, primary_r, primary_r};
    assign polar = ctrl_r[CTRL_POL_LO +: 4];

    // steering, static levels and shutdown override per output
    always_comb begin
        logic [1:0] ovr;
        ovr = OVR_IDLE;
        outLvl_nxt = 4'h0;
        outEn_nxt = 4'hF;
        for (int i = 0; i < 4; i++) begin
            if (steer_r[i]) begin
                outLvl_nxt[i] = wave4[i] ^ polar[i];
            end else begin
                outLvl_nxt[i] = steer_r[STEER_STATIC_LO + i];
            end
            if (shut_r) begin
                ovr = (i == 0 || i == 2) ? ctrl_r[CTRL_OVR_AC_LO +: 2]
                    : ctrl_r[CTRL_OVR_BD_LO +: 2];
                unique case (ovr)
                    OVR_HIGH: outLvl_nxt[i] = 1'b1;
                    OVR_LOW: outLvl_nxt[i] = 1'b0;
                    OVR_TRI: begin
                        outLvl_nxt[i] = 1'b0;
                        outEn_nxt[i] = 1'b0;
                    end
                    OVR_IDLE: outLvl_nxt[i] = polar[i];
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            shut_r <= 1'b0;
            wave_r <= 1'b0;
            primary_r <= 1'b0;
            compl_r <= 1'b0;
            blkCnt_r <= COUNT_RST;
            blkFall_r <= 1'b0;
            outLvl_r <= 4'h0;
            outEn_r <= 4'hF;
        end else begin
            shut_r <= shut_nxt;
            wave_r <= wave_nxt;
            primary_r <= primary_nxt;
            compl_r <= compl_nxt;
            blkCnt_r <= blkCnt_nxt;
            blkFall_r <= blkFall_nxt;
            outLvl_r <= outLvl_nxt;
            outEn_r <= outEn_nxt;
        end
    end

    assign hrdata = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign outputLevel = outLvl_r;
    assign outputEnable = outEn_r;
    assign irq = irq_r;
endmodule

// ==== tb/cos_check_assertions.sv ====
// port-level checks of the output steering block
`timescale 1ns/100ps
module cos_check
    import cos_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // shutdown sources
    input wire logic shutdownPinMapping,
    input wire logic comparator1Out,
    input wire logic comparator2Out,
    input wire logic logicCellTwoOutput,
    // driver outputs
    input wire logic [3:0] outputLevel,
    input wire logic [3:0] outputEnable
);
    logic wrPend_r, noShut_r, rdReq, shutReq;
    logic [7:0] wrAddr_r, steer_r, lowCnt_r;
    logic [3:0] srcEn_r, expLvl, expEn;
    logic [10:0] ctrl_r;
    logic [5:0] riseDb_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // read requests and the combined shutdown request
    assign rdReq = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    assign shutReq = |(srcEn_r & ~{logicCellTwoOutput, comparator2Out,
        comparator1Out, shutdownPinMapping});
    // override code to {enable, level}
    function automatic logic [1:0] ovr(input logic [1:0] c, input logic p);
        return {c != OVR_TRI, c == OVR_HIGH || (c == OVR_IDLE && p)};
    endfunction
    // what each pin shows in shutdown; pairs are a/c and b/d
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            {expEn[i], expLvl[i]} = ovr(ctrl_r[2 * (i % 2) +: 2],
                ctrl_r[4 + i]);
        end
    end
    // shadows of the written registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wrPend_r <= 1'b0;
            srcEn_r <= 4'h0;
            steer_r <= 8'h00;
            ctrl_r <= 11'h000;
            riseDb_r <= 6'h00;
            noShut_r <= 1'b1;
            lowCnt_r <= 8'h00;
        end else begin
            wrPend_r <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
            wrAddr_r <= haddr[7:0];
            noShut_r <= noShut_r && !shutReq;
            // saturates so a long low stretch never wraps
            lowCnt_r <= outputLevel[2] ? 8'h00 : lowCnt_r + {7'h0, ~&lowCnt_r};
            if (wrPend_r) begin
                case (wrAddr_r)
                    ADDR_SRC_EN: srcEn_r <= hwdata[3:0];
                    ADDR_STEER: steer_r <= hwdata[7:0];
                    ADDR_RISE_DB: riseDb_r <= hwdata[5:0];
                    ADDR_CTRL: ctrl_r <= hwdata[10:0];
                    default: ;
                endcase
            end
        end
    end
    // a and c steered, true polarity, settled
    sequence s_pair;
        (noShut_r && steer_r[0] && steer_r[2] && !ctrl_r[4] && !ctrl_r[6]
            && $stable(ctrl_r) && $stable(steer_r))[*3];
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bad bus answer");
    a_unmapped_zero: assert property (rdReq && haddr[7:0] > ADDR_INT_MASK
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    a_src_upper: assert property (rdReq && haddr[7:0] == ADDR_SRC_EN
        |=> hrdata[31:4] == 28'h0) else $error("enable upper set");
    a_count_upper: assert property (rdReq && haddr[7:0] inside
        {[ADDR_RISE_DB:ADDR_FALL_BLK]} |=> hrdata[31:6] == 26'h0)
        else $error("count upper bits set");
    a_static_steer: assert property ((noShut_r && $stable(steer_r))[*3]
        |-> ((outputLevel ^ steer_r[7:4]) & ~steer_r[3:0]) == 4'h0)
        else $error("static level wrong");
    a_ovr_levels: assert property ((shutReq && $stable(ctrl_r))[*3]
        |-> outputLevel == expLvl && outputEnable == expEn)
        else $error("shutdown override wrong");
    a_no_overlap: assert property (s_pair
        |-> !(outputLevel[0] && outputLevel[2]))
        else $error("pair overlap");
    a_rise_dead: assert property (s_pair ##0 $rose(outputLevel[0])
        |-> lowCnt_r > {2'h0, riseDb_r}) else $error("dead band too short");
    c_rise: cover property (s_pair ##0 $rose(outputLevel[0]));
    c_shut: cover property (shutReq[*3]);
    c_unmapped: cover property (rdReq && haddr[7:0] > ADDR_INT_MASK);
endmodule

bind cos_top cos_check chk_u (.sys_clk, .rst_b, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .shutdownPinMapping, .comparator1Out, .comparator2Out,
    .logicCellTwoOutput, .outputLevel, .outputEnable);

// ==== tb/cos_switch_model.sv ====
// four power switch drivers seen from the output pins
`timescale 1ns/100ps
module cos_switch_model
(
    // clock
    input wire logic sys_clk,
    // driver outputs from the block
    input wire logic [3:0] outputLevel,
    input wire logic [3:0] outputEnable,
    // level seen at each switch gate
    output logic [3:0] gateLevel
);
    logic [3:0] held_r;
    // no pull on the gates: a floating one keeps toggling
    always_ff @(posedge sys_clk) begin
        held_r <= gateLevel;
    end
    // driven gates follow the block, released ones show the inverse of their last level
    assign gateLevel = (outputEnable & outputLevel) | (~outputEnable & ~held_r);
endmodule

// ==== tb/testbench.sv ====
// self-checking bench of the output steering block
`timescale 1ns/100ps
module testbench
    import cos_pkg::*;
    ;
    logic sys_clk, rst_b, hsel, hwrite, hreadyout, hresp;
    logic riseEvent, fallEvent, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, ctl;
    logic [1:0] htrans, tb;
    logic [2:0] hsize;
    logic [3:0] src, outputLevel, outputEnable, gate, pol;
    logic [5:0] obs;
    logic [7:0] st;
    int n_fail, n_tests, c, rdb, fdb;
    assign obs = {hreadyout, irq, outputLevel};
    // sources: bit0 pin, 1 and 2 comparators, 3 logic cell
    cos_top dut_u (.sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .riseEvent, .fallEvent, .shutdownPinMapping(src[0]),
        .comparator1Out(src[1]), .comparator2Out(src[2]),
        .logicCellTwoOutput(src[3]), .outputLevel, .outputEnable, .irq);
    cos_switch_model sw_u (.sys_clk, .outputLevel, .outputEnable,
        .gateLevel(gate));
    // verdict and end of run
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // register and pin values
    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bounded wait on one observed bit
    task automatic waitObs(input int b, input logic v, output int n);
        n = 0;
        while (obs[b] !== v) begin
            @(posedge sys_clk);
            n++;
            if (n > 300) begin
                chkv(n, 0);
                conclude();
            end
        end
    endtask
    // single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int n;
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge sys_clk);
        waitObs(5, 1'b1, n);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        waitObs(5, 1'b1, n);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd);
        chkv(rd, e);
    endtask
    // one-cycle event pulse, then one idle cycle
    task automatic pulse(input logic r, input logic f);
        riseEvent <= r;
        fallEvent <= f;
        @(posedge sys_clk);
        riseEvent <= 1'b0;
        fallEvent <= 1'b0;
        @(posedge sys_clk);
    endtask
    // cycles between two pins settling
    task automatic gapOf(input int a, input logic va, input int b,
            input logic vb, input int e);
        int n;
        waitObs(a, va, n);
        waitObs(b, vb, n);
        chkv(n, e);
    endtask
    // dead time seen between the pins, zero count still costs one
    function automatic int dbExp(input int n, input logic chain);
        return (chain ? n * int'(CHAIN_STEP_CYC) : n) + 1;
    endfunction
    // steered pins: wave a,b low and c,d high after a fall
    function automatic logic [3:0] stExp(input logic [7:0] s,
            input logic [3:0] p);
        return (s[3:0] & (4'hC ^ p)) | (~s[3:0] & s[7:4]);
    endfunction
    // {enables, levels} in shutdown for the pair codes
    function automatic logic [7:0] ovExp(input logic [31:0] k);
        logic [1:0] cd;
        ovExp = 8'h00;
        for (int i = 0; i < 4; i++) begin
            cd = k[2 * (i % 2) +: 2];
            ovExp[i + 4] = cd != OVR_TRI;
            ovExp[i] = cd == OVR_HIGH || (cd == OVR_IDLE && k[4 + i]);
        end
    endfunction
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        {rst_b, hsel, hwrite, riseEvent, fallEvent} = 5'h00;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = HSIZE_WORD;
        src = 4'hF;
        n_fail = 0;
        n_tests = 0;
        c = $urandom(32'h62B0A531);
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        // reset values, then upper bits and an unmapped word
        for (int i = 0; i < 9; i++) begin
            rdc(8'(4 * i), 32'h0);
        end
        for (int i = 0; i < 6; i++) begin
            wr(8'(4 * i), 32'hFFFFFFFF);
            rdc(8'(4 * i), i == 0 ? 32'hF : i == 1 ? 32'hFF : 32'h3F);
            wr(8'(4 * i), 32'h0);
        end
        wr(8'h24, 32'hFFFFFFFF);
        rdc(8'h24, 32'h0);
        $display("test registers done");
        // dead band with corner and random counts, both time bases
        wr(ADDR_STEER, 32'hF);
        for (int i = 0; i < 6; i++) begin
            rdb = (i == 0) ? 0 : (i == 1) ? 63 : int'($urandom % 64);
            fdb = (i == 0) ? 63 : (i == 1) ? 0 : int'($urandom % 64);
            tb = 2'($urandom);
            wr(ADDR_RISE_DB, 32'(rdb));
            wr(ADDR_FALL_DB, 32'(fdb));
            wr(ADDR_CTRL, 32'(tb) << CTRL_RISE_TB);
            pulse(1'b0, 1'b1);
            waitObs(2, 1'b1, c);
            pulse(1'b1, 1'b0);
            gapOf(2, 1'b0, 0, 1'b1, dbExp(rdb, tb[0]));
            pulse(1'b0, 1'b1);
            gapOf(0, 1'b0, 2, 1'b1, dbExp(fdb, tb[1]));
        end
        $display("test dead band done");
        // an event inside the other edge's blanking is dropped
        wr(ADDR_RISE_DB, 32'h0);
        wr(ADDR_FALL_DB, 32'h0);
        wr(ADDR_RISE_BLK, 32'hA);
        wr(ADDR_FALL_BLK, 32'hA);
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b1);
        repeat (20) @(posedge sys_clk);
        chkv(32'(outputLevel[0]), 32'h1);
        pulse(1'b0, 1'b1);
        waitObs(0, 1'b0, c);
        pulse(1'b1, 1'b0);
        repeat (20) @(posedge sys_clk);
        chkv(32'(outputLevel[0]), 32'h0);
        wr(ADDR_RISE_BLK, 32'h0);
        wr(ADDR_FALL_BLK, 32'h0);
        $display("test blanking done");
        // steering against static levels with random polarity
        for (int i = 0; i < 8; i++) begin
            st = (i == 0) ? 8'hF0 : (i == 1) ? 8'h0F : 8'($urandom);
            pol = 4'($urandom);
            wr(ADDR_STEER, 32'(st));
            wr(ADDR_CTRL, 32'(pol) << CTRL_POL_LO);
            repeat (3) @(posedge sys_clk);
            chkv(32'(outputLevel), 32'(stExp(st, pol)));
            chkv(32'(gate), 32'(stExp(st, pol)));
            chkv(32'(outputEnable), 32'hF);
        end
        $display("test steering done");
        // interrupt raised, cleared, then masked
        wr(ADDR_STEER, 32'hF);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_INT_MASK, 32'h1 << IRQ_RISE);
        wr(ADDR_INT_STAT, 32'h7);
        rdc(ADDR_INT_STAT, 32'h0);
        pulse(1'b1, 1'b0);
        waitObs(4, 1'b1, c);
        rdc(ADDR_INT_STAT, 32'h1 << IRQ_RISE);
        wr(ADDR_INT_STAT, 32'h1 << IRQ_RISE);
        waitObs(4, 1'b0, c);
        wr(ADDR_INT_MASK, 32'h0);
        pulse(1'b0, 1'b1);
        repeat (4) @(posedge sys_clk);
        chkv(32'(irq), 32'h0);
        rdc(ADDR_INT_STAT, 32'h1 << IRQ_FALL);
        $display("test interrupt done");
        // each source alone, disabled and then among all enabled
        for (int i = 0; i < 4; i++) begin
            pol = 4'($urandom);
            ctl = (32'(3 - i) << CTRL_OVR_BD_LO) | 32'(i)
                | (32'(pol) << CTRL_POL_LO);
            wr(ADDR_CTRL, ctl);
            wr(ADDR_SRC_EN, 32'hF ^ (32'h1 << i));
            src <= 4'hF ^ (4'h1 << i);
            repeat (4) @(posedge sys_clk);
            rdc(ADDR_CTRL, ctl);
            wr(ADDR_SRC_EN, 32'hF);
            repeat (4) @(posedge sys_clk);
            rdc(ADDR_CTRL, ctl | (32'h1 << CTRL_SHUT_FLAG));
            chkv(32'({outputEnable, outputLevel}), 32'(ovExp(ctl)));
            src <= 4'hF;
            wr(ADDR_CTRL, ctl);
            rdc(ADDR_CTRL, ctl);
        end
        // auto restart leaves shutdown at the next rising event
        ctl = 32'h1 << CTRL_RESTART;
        wr(ADDR_CTRL, ctl);
        src <= 4'hE;
        repeat (4) @(posedge sys_clk);
        rdc(ADDR_CTRL, ctl | (32'h1 << CTRL_SHUT_FLAG));
        src <= 4'hF;
        pulse(1'b1, 1'b0);
        rdc(ADDR_CTRL, ctl);
        $display("test shutdown done");
        conclude();
    end
endmodule
